// ===== hdl/eeim_map.svh
`ifndef EEIM_MAP_SVH
`define EEIM_MAP_SVH

// Register indices; the byte address is four times the index
`define EEIM_IDX_MASK 16'he50a
`define EEIM_IDX_STATUS 16'he520
`define EEIM_IDX_CLEAR 16'he521
`define EEIM_IDX_ACCUMULATION_MODE_REG 16'he522
`define EEIM_IDX_PULSE_OUTPUT_MODE_REG 16'he523

// Reset values
`define EEIM_RST_MASK 19'h00000
`define EEIM_RST_ACCUMULATION_MODE_REG 2'h0
`define EEIM_RST_PULSE_OUTPUT_MODE_REG 12'h000

// Flag bit positions (status, clear and mask share them)
`define EEIM_B_TAHF 0
`define EEIM_B_FAHF 1
`define EEIM_B_TRHF 2
`define EEIM_B_FRHF 3
`define EEIM_B_APHF 4
`define EEIM_B_LINE 5
`define EEIM_B_SGNA 6
`define EEIM_B_SUM1 9
`define EEIM_B_SGNR 10
`define EEIM_B_SUM2 13
`define EEIM_B_PUL1 14
`define EEIM_B_DSP 17
`define EEIM_B_SUM3 18
`define EEIM_NFLAGS 19

// Accumulation-mode register fields, packed low
`define EEIM_ACC_ACTSEL 0
`define EEIM_ACC_REACTSEL 1
// Positions of the same fields on the bus word
`define EEIM_ACC_ACTSEL_BUS 6
`define EEIM_ACC_REACTSEL_BUS 7

// Pulse-output mode fields
`define EEIM_CF_SEL1_LO 0
`define EEIM_CF_SEL2_LO 3
`define EEIM_CF_SEL3_LO 6
`define EEIM_CF_DIS1 9
`define EEIM_CF_DIS2 10
`define EEIM_CF_DIS3 11
`define EEIM_CF_WIDTH 12

// Change-detector input vector layout
`define EEIM_V_TA 0
`define EEIM_V_FA 3
`define EEIM_V_TR 6
`define EEIM_V_FR 9
`define EEIM_V_AP 12
`define EEIM_V_SA 15
`define EEIM_V_SR 18
`define EEIM_V_SUM 21
`define EEIM_V_PUL 24
`define EEIM_V_W 27

`endif

// ===== hdl/eeim_pkg.sv
package eeim_pkg;
    typedef logic [18:0] eeim_flags_type;
    typedef logic [2:0] eeim_power_sel_type;
    typedef logic [11:0] eeim_pulse_output_mode_reg_type;
endpackage : eeim_pkg

// ===== hdl/eeim_change_det.sv
`timescale 1ns/1ns
module eeim_change_det #(
    parameter int WIDTH = 27
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] changed,
    output logic [WIDTH-1:0] fell
);
    logic [WIDTH-1:0] prev_q;
    logic armed_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_q <= '0;
            armed_q <= 1'b0;
        end
        else if (ce)
        begin
            prev_q <= level;
            armed_q <= 1'b1;
        end
    end

    // No event until one real sample is held
    assign changed = armed_q ? (prev_q ^ level) : '0;
    assign fell = armed_q ? (prev_q & ~level) : '0;
endmodule : eeim_change_det

// ===== hdl/eeim_irq_mask.sv
`timescale 1ns/1ns
`include "eeim_map.svh"
// Function
// - With enable bit 0 set, a change of bit 30 in any phase total active energy raises an interrupt.
// - With enable bit 1 set, a change of bit 30 in any phase fundamental active energy interrupts, unless the variant lacks fundamental measurement.
// - With enable bit 2 set, a change of bit 30 in any phase total reactive energy interrupts, unless the variant lacks reactive measurement.
// - With enable bit 3 set, a change of bit 30 in any phase fundamental reactive energy interrupts, unless the variant lacks fundamental measurement.
// - With enable bit 4 set, a change of bit 30 in any phase apparent energy raises an interrupt.
// - With enable bit 5 set in line-cycle mode, the end of the half-cycle integration raises an interrupt.
// - Enable bits 6 to 8 give interrupts on active power sign change of phase A, B, C, total or fundamental by mode bit 6.
// - Enable bits 10 to 12 give the same for reactive power, selected by mode bit 7, ignored without reactive measurement.
// - Enable bits 9, 13 and 18 give interrupts when the summed power of pulse path 1, 2 or 3 changes sign.
// - Enable bits 14 to 16 give interrupts on each falling edge of pulse output 1, 2 or 3.
// - A pulse interrupt still occurs while that pulse pin is disabled by mode bit 9, 10 or 11.
// - The power feeding pulse outputs 1 to 3 is chosen by mode fields [2:0], [5:3] and [8:6].
// - With enable bit 17 set, each end of the 8 kHz processing cycle raises an interrupt.
// - Enable bits 31 to 19 are reserved and have no effect whatever is written.
// - Every enable bit is 0 after reset.
module eeim_irq_mask
    import eeim_pkg::*;
#(
    parameter bit HAS_FUND = 1'b1,
    parameter bit HAS_REACTIVE = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Avalon-MM slave, byte address
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Bit 30 of each accumulator, phases A, B, C in bits 0, 1, 2
    input wire logic [2:0] total_active_bit30,
    input wire logic [2:0] fund_active_bit30,
    input wire logic [2:0] total_reactive_bit30,
    input wire logic [2:0] fund_reactive_bit30,
    input wire logic [2:0] apparent_bit30,
    // Power signs, 1 = negative
    input wire logic [2:0] total_active_sign,
    input wire logic [2:0] fund_active_sign,
    input wire logic [2:0] total_reactive_sign,
    input wire logic [2:0] fund_reactive_sign,
    input wire logic [2:0] pulse_sum_sign,
    // Internal pulse levels, before the pin disables
    input wire logic pulse_out_first,
    input wire logic pulse_out_second,
    input wire logic pulse_out_third,
    input wire logic line_cycle_mode,
    input wire logic line_cycle_done,
    input wire logic dsp_cycle_done,
    output logic [2:0] pulse_first_power_sel,
    output logic [2:0] pulse_second_power_sel,
    output logic [2:0] pulse_third_power_sel,
    output logic pulse_first_disable,
    output logic pulse_second_disable,
    output logic pulse_third_disable,
    output logic active_sign_source_sel,
    output logic reactive_sign_source_sel,
    output logic irq
);
    localparam logic [15:0] IDX_MASK = `EEIM_IDX_MASK;
    localparam logic [15:0] IDX_STATUS = `EEIM_IDX_STATUS;
    localparam logic [15:0] IDX_CLEAR = `EEIM_IDX_CLEAR;
    localparam logic [15:0] IDX_ACCUMULATION_MODE_REG = `EEIM_IDX_ACCUMULATION_MODE_REG;
    localparam logic [15:0] IDX_PULSE_OUTPUT_MODE_REG = `EEIM_IDX_PULSE_OUTPUT_MODE_REG;

    eeim_flags_type irq_enable_mask_a_q;
    eeim_flags_type status_q;
    eeim_flags_type status_d;
    eeim_flags_type event_set;
    eeim_flags_type clear_bits;
    eeim_pulse_output_mode_reg_type pulse_output_mode_reg_q;
    logic [1:0] accumulation_mode_reg_q;
    logic [31:0] readdata_q;
    logic waitrequest_q;
    logic irq_q;

    // Apply byte enables to an old value
    function automatic logic [31:0] eeim_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : eeim_merge

    // Bus decode
    wire word_aligned = (avs_address[1:0] == 2'h0);
    wire [15:0] word_idx = avs_address[17:2];
    wire req = avs_read | avs_write;
    // Access completes at the edge where waitrequest is seen low
    wire access_done = req & ~waitrequest_q;
    wire wr_done = access_done & avs_write;
    wire hit_mask = word_aligned & (word_idx == IDX_MASK);
    wire hit_status = word_aligned & (word_idx == IDX_STATUS);
    wire hit_clear = word_aligned & (word_idx == IDX_CLEAR);
    wire hit_acc = word_aligned & (word_idx == IDX_ACCUMULATION_MODE_REG);
    wire hit_cf = word_aligned & (word_idx == IDX_PULSE_OUTPUT_MODE_REG);

    wire [31:0] mask_word = {13'h0000, irq_enable_mask_a_q};
    wire [31:0] status_word = {13'h0000, status_q};
    wire [31:0] acc_word = {24'h000000, accumulation_mode_reg_q, 6'h00};
    wire [31:0] cf_word = {20'h00000, pulse_output_mode_reg_q};
    wire [31:0] mask_new = eeim_merge(mask_word, avs_writedata, avs_byteenable);
    wire [31:0] acc_new = eeim_merge(acc_word, avs_writedata, avs_byteenable);
    wire [31:0] cf_new = eeim_merge(cf_word, avs_writedata, avs_byteenable);
    wire [31:0] clr_new = eeim_merge(32'h00000000, avs_writedata, avs_byteenable);

    // Unmapped and write-only words read as zero
    wire [31:0] read_mux = hit_mask ? mask_word :
                           hit_status ? status_word :
                           hit_acc ? acc_word :
                           hit_cf ? cf_word : 32'h00000000;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waitrequest_q <= 1'b1;
            readdata_q <= 32'h00000000;
        end
        else if (ce)
        begin
            waitrequest_q <= ~(req & waitrequest_q);
            if (avs_read & waitrequest_q)
            begin
                readdata_q <= read_mux;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_enable_mask_a_q <= `EEIM_RST_MASK;
            accumulation_mode_reg_q <= `EEIM_RST_ACCUMULATION_MODE_REG;
            pulse_output_mode_reg_q <= `EEIM_RST_PULSE_OUTPUT_MODE_REG;
        end
        else if (ce & wr_done)
        begin
            if (hit_mask)
            begin
                irq_enable_mask_a_q <= mask_new[`EEIM_NFLAGS-1:0];
            end
            if (hit_acc)
            begin
                accumulation_mode_reg_q <= acc_new[`EEIM_ACC_REACTSEL_BUS:`EEIM_ACC_ACTSEL_BUS];
            end
            if (hit_cf)
            begin
                pulse_output_mode_reg_q <= cf_new[`EEIM_CF_WIDTH-1:0];
            end
        end
    end

    // Event sources
    logic [`EEIM_V_W-1:0] det_level;
    logic [`EEIM_V_W-1:0] det_changed;
    logic [`EEIM_V_W-1:0] det_fell;
    wire act_sel = accumulation_mode_reg_q[`EEIM_ACC_ACTSEL];
    wire react_sel = accumulation_mode_reg_q[`EEIM_ACC_REACTSEL];
    // sign source by mode bit 6
    wire [2:0] active_sign = act_sel ? fund_active_sign : total_active_sign;
    // sign source by mode bit 7
    wire [2:0] reactive_sign = react_sel ? fund_reactive_sign : total_reactive_sign;

    assign det_level = {pulse_out_third, pulse_out_second, pulse_out_first,
                        pulse_sum_sign, reactive_sign, active_sign,
                        apparent_bit30, fund_reactive_bit30, total_reactive_bit30,
                        fund_active_bit30, total_active_bit30};

    eeim_change_det #(
        .WIDTH(`EEIM_V_W)
    ) u_det (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .level(det_level),
        .changed(det_changed),
        .fell(det_fell)
    );

    assign event_set[`EEIM_B_TAHF] = |det_changed[`EEIM_V_TA +: 3];
    assign event_set[`EEIM_B_FAHF] = HAS_FUND & (|det_changed[`EEIM_V_FA +: 3]);
    assign event_set[`EEIM_B_TRHF] = HAS_REACTIVE & (|det_changed[`EEIM_V_TR +: 3]);
    assign event_set[`EEIM_B_FRHF] = HAS_FUND & (|det_changed[`EEIM_V_FR +: 3]);
    assign event_set[`EEIM_B_APHF] = |det_changed[`EEIM_V_AP +: 3];
    assign event_set[`EEIM_B_LINE] = line_cycle_mode & line_cycle_done;
    assign event_set[`EEIM_B_SGNA +: 3] = det_changed[`EEIM_V_SA +: 3];
    assign event_set[`EEIM_B_SGNR +: 3] = HAS_REACTIVE ? det_changed[`EEIM_V_SR +: 3] : 3'h0;
    assign event_set[`EEIM_B_SUM1] = det_changed[`EEIM_V_SUM];
    assign event_set[`EEIM_B_SUM2] = det_changed[`EEIM_V_SUM + 1];
    assign event_set[`EEIM_B_SUM3] = det_changed[`EEIM_V_SUM + 2];
    assign event_set[`EEIM_B_PUL1 +: 3] = det_fell[`EEIM_V_PUL +: 3];
    assign event_set[`EEIM_B_DSP] = dsp_cycle_done;

    // Write-one-to-clear; a new event wins over a clear
    assign clear_bits = (wr_done & hit_clear) ? clr_new[`EEIM_NFLAGS-1:0] : '0;
    assign status_d = (status_q & ~clear_bits) | event_set;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_q <= '0;
            irq_q <= 1'b0;
        end
        else if (ce)
        begin
            status_q <= status_d;
            irq_q <= |(status_d & irq_enable_mask_a_q);
        end
    end

    assign avs_readdata = readdata_q;
    assign avs_waitrequest = waitrequest_q;
    assign irq = irq_q;
    assign pulse_first_power_sel = pulse_output_mode_reg_q[`EEIM_CF_SEL1_LO +: 3];
    assign pulse_second_power_sel = pulse_output_mode_reg_q[`EEIM_CF_SEL2_LO +: 3];
    assign pulse_third_power_sel = pulse_output_mode_reg_q[`EEIM_CF_SEL3_LO +: 3];
    assign pulse_first_disable = pulse_output_mode_reg_q[`EEIM_CF_DIS1];
    assign pulse_second_disable = pulse_output_mode_reg_q[`EEIM_CF_DIS2];
    assign pulse_third_disable = pulse_output_mode_reg_q[`EEIM_CF_DIS3];
    assign active_sign_source_sel = act_sel;
    assign reactive_sign_source_sel = react_sel;
endmodule : eeim_irq_mask

// ===== tb/eeim_irq_mask_properties.sv
`timescale 1ns/1ns
module eeim_irq_mask_properties
    import eeim_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] total_active_bit30,
    input wire logic [2:0] apparent_bit30,
    input wire logic [2:0] total_active_sign,
    input wire logic [2:0] pulse_sum_sign,
    input wire logic pulse_out_first,
    input wire logic pulse_out_second,
    input wire logic pulse_out_third,
    input wire logic line_cycle_mode,
    input wire logic line_cycle_done,
    input wire logic dsp_cycle_done,
    input wire logic [2:0] pulse_first_power_sel,
    input wire logic pulse_third_disable,
    input wire logic active_sign_source_sel,
    input wire logic irq
);
    logic [31:0] m_q;
    logic armed_q;
    wire [18:0] m = m_q[18:0];
    wire wr_mask = avs_write && !avs_waitrequest && avs_address == 18'h39428;
    // Shadow of the enable mask as written over the bus
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            m_q <= 32'h0;
            armed_q <= 1'b0;
        end
        else
        begin
            armed_q <= 1'b1;
            for (int i = 0; i < 4; i++)
                if (wr_mask && avs_byteenable[i])
                    m_q[8*i+:8] <= avs_writedata[8*i+:8];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_off;
        m == 19'h0 ##1 m == 19'h0;
    endsequence
    property p_tact;
        armed_q && m[0] && $changed(total_active_bit30) |=> irq;
    endproperty
    a_tact: assert property (p_tact) else $error("energy change irq");
    property p_app;
        armed_q && m[4] && $changed(apparent_bit30) |=> irq;
    endproperty
    a_app: assert property (p_app) else $error("apparent irq");
    property p_line;
        m[5] && line_cycle_mode && line_cycle_done |=> irq;
    endproperty
    a_line: assert property (p_line) else $error("line irq");
    property p_asgn;
        armed_q && !active_sign_source_sel
            && |(m[8:6] & (total_active_sign ^ $past(total_active_sign))) |=> irq;
    endproperty
    a_asgn: assert property (p_asgn) else $error("sign irq");
    property p_sum;
        armed_q && |({m[18], m[13], m[9]} & (pulse_sum_sign ^ $past(pulse_sum_sign))) |=> irq;
    endproperty
    a_sum: assert property (p_sum) else $error("sum irq");
    property p_pul;
        armed_q && (m[14] && $fell(pulse_out_first) || m[15] && $fell(pulse_out_second)
            || m[16] && $fell(pulse_out_third)) |=> irq;
    endproperty
    a_pul: assert property (p_pul) else $error("pulse irq");
    property p_dsp;
        m[17] && dsp_cycle_done |=> irq;
    endproperty
    a_dsp: assert property (p_dsp) else $error("dsp irq");
    property p_resv;
        avs_read && !avs_waitrequest && avs_address == 18'h39428 |-> avs_readdata[31:19] == 13'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits");
    property p_rst;
        $rose(rst_b) |-> !irq && pulse_first_power_sel == 3'h0 && !pulse_third_disable;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_off;
        s_off |-> !irq;
    endproperty
    a_off: assert property (p_off) else $error("irq while masked");
endmodule : eeim_irq_mask_properties

// ===== tb/eeim_irq_mask_tb.sv
`timescale 1ns/1ns
module eeim_irq_mask_tb;
    import eeim_pkg::*;
    localparam logic [17:0] A_MASK = 18'h39428;
    localparam logic [17:0] A_STAT = 18'h39480;
    localparam logic [17:0] A_CLR = 18'h39484;
    logic clk, rst_b, ce, rd, wr, wq, irq, p1, p2, p3, lm, ld, dd, dis1, dis2, dis3, asel, rsel;
    logic [17:0] adr;
    logic [31:0] wd, rdat, r;
    logic [3:0] be;
    logic [2:0] tab, fab, trb, frb, apb, tas, fas, trs, frs, pss, sel1, sel2, sel3;
    logic [31:0] expq[$];
    int n_fail, compares;
    eeim_irq_mask uut (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wq), .total_active_bit30(tab), .fund_active_bit30(fab),
        .total_reactive_bit30(trb), .fund_reactive_bit30(frb), .apparent_bit30(apb),
        .total_active_sign(tas), .fund_active_sign(fas), .total_reactive_sign(trs),
        .fund_reactive_sign(frs), .pulse_sum_sign(pss), .pulse_out_first(p1),
        .pulse_out_second(p2), .pulse_out_third(p3), .line_cycle_mode(lm),
        .line_cycle_done(ld), .dsp_cycle_done(dd), .pulse_first_power_sel(sel1),
        .pulse_second_power_sel(sel2), .pulse_third_power_sel(sel3),
        .pulse_first_disable(dis1), .pulse_second_disable(dis2), .pulse_third_disable(dis3),
        .active_sign_source_sel(asel), .reactive_sign_source_sel(rsel), .irq(irq));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        compares++;
        if (e !== s)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(logic w, logic [17:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rd_exp(logic [17:0] a, logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd_exp
    task automatic fire(int b);
        int k;
        k = $urandom_range(2);
        @(posedge clk);
        case (b)
            0: tab[k] <= !tab[k];
            1: fab[k] <= !fab[k];
            2: trb[k] <= !trb[k];
            3: frb[k] <= !frb[k];
            4: apb[k] <= !apb[k];
            5: ld <= 1'b1;
            6, 7, 8: tas[b-6] <= !tas[b-6];
            9: pss[0] <= !pss[0];
            10, 11, 12: trs[b-10] <= !trs[b-10];
            13: pss[1] <= !pss[1];
            14: p1 <= 1'b0;
            15: p2 <= 1'b0;
            16: p3 <= 1'b0;
            17: dd <= 1'b1;
            default: pss[2] <= !pss[2];
        endcase
        @(posedge clk);
        {ld, dd, p1, p2, p3} <= 5'b00111;
        repeat (3) @(posedge clk);
    endtask : fire
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Read data is compared against the oldest note
    always @(posedge clk)
        if (rd && wq === 1'b0)
            chk("readdata", expq.pop_front(), rdat);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end
    initial
    begin
        {rst_b, rd, wr, ld, dd, adr, wd, tab, fab, trb, frb, apb} = '0;
        {tas, fas, trs, frs, pss} = '0;
        {p1, p2, p3, lm, be} = 8'hff;
        ce = 1'b1;
        void'($urandom(32'h95d38605));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_exp(A_MASK, 32'h0);
        rd_exp(18'h3948c, 32'h0);
        chk("irq", 32'h0, irq);
        $display("reset test done");
        r = $urandom;
        bus(1'b1, A_MASK, r);
        rd_exp(A_MASK, {13'h0, r[18:0]});
        rd_exp(18'h39400, 32'h0);
        bus(1'b1, A_MASK, 32'hfff80000);
        fire(17);
        chk("irq", 32'h0, irq);
        r = ($urandom & 32'h1ff) | 32'he00;
        bus(1'b1, 18'h3948c, r);
        // Register outputs settle after the completing edge
        @(posedge clk);
        chk("sel", r[8:0], {sel3, sel2, sel1});
        chk("dis", 32'h7, {dis3, dis2, dis1});
        $display("register test done");
        for (int b = 0; b < 19; b++)
        begin
            bus(1'b1, A_CLR, 32'h7ffff);
            bus(1'b1, A_MASK, ~(32'h1 << b));
            fire(b);
            chk("irq masked", 32'h0, irq);
            rd_exp(A_STAT, 32'h1 << b);
            bus(1'b1, A_MASK, 32'h1 << b);
            repeat (2) @(posedge clk);
            chk("irq", 32'h1, irq);
            bus(1'b1, A_CLR, 32'h1 << b);
            repeat (2) @(posedge clk);
            chk("irq cleared", 32'h0, irq);
            fire(b);
            chk("irq enabled", 32'h1, irq);
        end
        $display("event test done");
        // Switching the sign source may itself flag events, so clear afterwards
        bus(1'b1, 18'h39488, 32'hc0);
        @(posedge clk);
        chk("source sel", 32'h3, {rsel, asel});
        repeat (3) @(posedge clk);
        bus(1'b1, A_CLR, 32'h7ffff);
        fas[1] <= !fas[1];
        frs[0] <= !frs[0];
        repeat (3) @(posedge clk);
        rd_exp(A_STAT, 32'h480);
        bus(1'b1, A_CLR, 32'h7ffff);
        lm <= 1'b0;
        fire(5);
        rd_exp(A_STAT, 32'h0);
        $display("mode test done");
        // Clock enable low freezes the flags
        ce <= 1'b0;
        fire(17);
        ce <= 1'b1;
        rd_exp(A_STAT, 32'h0);
        $display("enable test done");
        test_done();
    end
endmodule : eeim_irq_mask_tb
bind eeim_irq_mask eeim_irq_mask_properties u_prop (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .total_active_bit30(total_active_bit30), .apparent_bit30(apparent_bit30),
    .total_active_sign(total_active_sign), .pulse_sum_sign(pulse_sum_sign),
    .pulse_out_first(pulse_out_first), .pulse_out_second(pulse_out_second),
    .pulse_out_third(pulse_out_third), .line_cycle_mode(line_cycle_mode),
    .line_cycle_done(line_cycle_done), .dsp_cycle_done(dsp_cycle_done),
    .pulse_first_power_sel(pulse_first_power_sel), .pulse_third_disable(pulse_third_disable),
    .active_sign_source_sel(active_sign_source_sel), .irq(irq));
